// >>> inc/mrr_map.vh
// register offsets, field positions and reset values of the motion report register set
`ifndef MRR_MAP_VH
`define MRR_MAP_VH
`define MRR_OFS_STATUS 8'h02
`define MRR_OFS_XCNT 8'h03
`define MRR_OFS_YCNT 8'h04
`define MRR_OFS_SURFACE_QUALITY 8'h05
`define MRR_OFS_PIXSUM 8'h06
`define MRR_OFS_PEAK 8'h07
`define MRR_OFS_RSVA 8'h08
`define MRR_OFS_RSVB 8'h09
`define MRR_OFS_SETUP 8'h0a
`define MRR_OFS_FLUSH 8'h12
`define MRR_OFS_IRQ_STAT 8'h20
`define MRR_OFS_IRQ_MASK 8'h21
`define MRR_SETUP_RST 8'h49
`define MRR_SETUP_WMASK 8'h74
`define MRR_SETUP_FIXED 8'h08
`define MRR_ST_MOT 7
`define MRR_ST_OVF 4
`define MRR_ST_RESOLUTION_HIGH_BIT 2
`define MRR_ST_RESOLUTION_LOW_BIT 0
`define MRR_CFG_RESOLUTION_HIGH_BIT 4
`define MRR_CFG_RESOLUTION_LOW_BIT 2
`define MRR_IRQ_MOT 0
`define MRR_IRQ_OVF 1
`define MRR_IRQ_FRAME 2
`define MRR_PIX_COUNT 900
`define MRR_SURFACE_QUALITY_MAX 8'ha9
`endif

// >>> rtl/mrr_motion_regs.v
// motion report and frame statistics registers behind a classic wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "mrr_map.vh"

module mrr_motion_regs #(
	parameter ACC_W = 12,
	parameter DELTA_W = 8
) (
	// clock, reset, enable
	input wire ref_clk_i,
	input wire resetn_i,
	input wire clk_en_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// navigation engine, same clock
	input wire mot_valid_i,
	input wire [DELTA_W-1:0] mot_dx_i,
	input wire [DELTA_W-1:0] mot_dy_i,
	input wire pix_valid_i,
	input wire [5:0] pix_val_i,
	input wire frame_start_i,
	input wire frame_end_i,
	input wire feat_valid_i,
	// configuration out
	output reg [1:0] res_sel_o,
	output reg laser_mode_o,
	output reg sys_test_o,
	// interrupt
	output reg irq_o
);

	localparam [ACC_W-1:0] ACC_PMAX = {1'b0, {(ACC_W-1){1'b1}}};
	localparam [ACC_W-1:0] ACC_NMAX = {1'b1, {(ACC_W-1){1'b0}}};
	localparam [ACC_W-1:0] SAT_P = 8'h7f;
	localparam [ACC_W-1:0] SAT_N = {{(ACC_W-8){1'b1}}, 8'h80};

	reg [ACC_W-1:0] acc_x_ff;
	reg [ACC_W-1:0] acc_y_ff;
	reg [7:0] cnt_x_ff;
	reg [7:0] cnt_y_ff;
	reg ovf_ff;
	reg [7:0] setup_ff;
	reg [9:0] feat_cnt_ff;
	reg [7:0] surface_quality_ff;
	reg [15:0] pix_sum_ff;
	reg [7:0] pix_hi_ff;
	reg [5:0] peak_run_ff;
	reg [5:0] peak_ff;
	reg [2:0] irq_stat_ff;
	reg [2:0] irq_mask_ff;

	// saturate a wide accumulator to the signed eight bit range
	function [ACC_W-1:0] sat8;
		input [ACC_W-1:0] v;
		begin
			if (!v[ACC_W-1] && v > SAT_P)
				sat8 = SAT_P;
			else if (v[ACC_W-1] && v < SAT_N)
				sat8 = SAT_N;
			else
				sat8 = v;
		end
	endfunction

	// add a signed delta to an accumulator, clipping at full scale
	function [ACC_W:0] acc_add;
		input [ACC_W-1:0] a;
		input [DELTA_W-1:0] d;
		reg [ACC_W:0] s;
		begin
			s = {a[ACC_W-1], a} + {{(ACC_W+1-DELTA_W){d[DELTA_W-1]}}, d};
			if (s[ACC_W] != s[ACC_W-1])
				acc_add = {1'b1, (s[ACC_W] ? ACC_NMAX : ACC_PMAX)};
			else
				acc_add = {1'b0, s[ACC_W-1:0]};
		end
	endfunction

	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire rd = req & ~wb_we_i;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd_stat = rd && wb_adr_i == `MRR_OFS_STATUS;
	wire rd_x = rd && wb_adr_i == `MRR_OFS_XCNT;
	wire rd_y = rd && wb_adr_i == `MRR_OFS_YCNT;
	wire flush = wr && wb_adr_i == `MRR_OFS_FLUSH;
	wire [ACC_W-1:0] lat_x = sat8(acc_x_ff);
	wire [ACC_W-1:0] lat_y = sat8(acc_y_ff);
	wire [ACC_W:0] sum_x = acc_add(rd_stat ? acc_x_ff - lat_x : acc_x_ff, mot_dx_i);
	wire [ACC_W:0] sum_y = acc_add(rd_stat ? acc_y_ff - lat_y : acc_y_ff, mot_dy_i);
	wire at_full = acc_x_ff == ACC_PMAX || acc_x_ff == ACC_NMAX ||
		acc_y_ff == ACC_PMAX || acc_y_ff == ACC_NMAX;
	wire mot_pend = acc_x_ff != {ACC_W{1'b0}} || acc_y_ff != {ACC_W{1'b0}} ||
		cnt_x_ff != 8'h00 || cnt_y_ff != 8'h00;
	wire ovf_evt = mot_valid_i && (sum_x[ACC_W] || sum_y[ACC_W]);
	wire [5:0] pk_now = (pix_val_i > peak_run_ff) ? pix_val_i : peak_run_ff;
	wire [7:0] status = {mot_pend, 2'b00, ovf_ff, 1'b0, setup_ff[`MRR_CFG_RESOLUTION_HIGH_BIT], 1'b0,
		setup_ff[`MRR_CFG_RESOLUTION_LOW_BIT]};

	// motion accumulators and latched counts
	always @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			acc_x_ff <= {ACC_W{1'b0}};
			acc_y_ff <= {ACC_W{1'b0}};
			cnt_x_ff <= 8'h00;
			cnt_y_ff <= 8'h00;
			ovf_ff <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (flush)
			begin
				acc_x_ff <= {ACC_W{1'b0}};
				acc_y_ff <= {ACC_W{1'b0}};
				cnt_x_ff <= 8'h00;
				cnt_y_ff <= 8'h00;
				ovf_ff <= 1'b0;
			end
			else
			begin
				if (rd_stat)
				begin
					// earlier unread counts are replaced
					cnt_x_ff <= lat_x[7:0];
					cnt_y_ff <= lat_y[7:0];
				end
				else
				begin
					if (rd_x)
						cnt_x_ff <= 8'h00;
					if (rd_y)
						cnt_y_ff <= 8'h00;
				end
				// residue stays and keeps the motion flag up
				if (mot_valid_i)
				begin
					acc_x_ff <= sum_x[ACC_W-1:0];
					acc_y_ff <= sum_y[ACC_W-1:0];
				end
				else if (rd_stat)
				begin
					acc_x_ff <= acc_x_ff - lat_x;
					acc_y_ff <= acc_y_ff - lat_y;
				end
				// set wins over clear
				if (ovf_evt)
					ovf_ff <= 1'b1;
				else if ((rd_x || rd_y) && !at_full)
					ovf_ff <= 1'b0;
			end
		end
	end

	// per-frame statistics
	always @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			feat_cnt_ff <= 10'h000;
			surface_quality_ff <= 8'h00;
			pix_sum_ff <= 16'h0000;
			pix_hi_ff <= 8'h00;
			peak_run_ff <= 6'h00;
			peak_ff <= 6'h00;
		end
		else if (clk_en_i)
		begin
			if (frame_start_i)
			begin
				feat_cnt_ff <= 10'h000;
				pix_sum_ff <= 16'h0000;
				peak_run_ff <= 6'h00;
			end
			else
			begin
				if (feat_valid_i && feat_cnt_ff != 10'h3ff)
					feat_cnt_ff <= feat_cnt_ff + 10'h001;
				if (pix_valid_i)
				begin
					pix_sum_ff <= pix_sum_ff + {10'h000, pix_val_i};
					peak_run_ff <= pk_now;
				end
			end
			if (frame_end_i)
			begin
				if (feat_cnt_ff[9:2] > `MRR_SURFACE_QUALITY_MAX)
					surface_quality_ff <= `MRR_SURFACE_QUALITY_MAX;
				else
					surface_quality_ff <= feat_cnt_ff[9:2];
				pix_hi_ff <= pix_sum_ff[15:8];
				peak_ff <= peak_run_ff;
			end
		end
	end

	// wishbone register access, one wait state per transfer
	always @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			setup_ff <= `MRR_SETUP_RST;
			irq_mask_ff <= 3'h0;
		end
		else if (clk_en_i)
		begin
			wb_ack_o <= req;
			if (rd)
			begin
				case (wb_adr_i)
					`MRR_OFS_STATUS: wb_dat_o <= {24'h000000, status};
					`MRR_OFS_XCNT: wb_dat_o <= {24'h000000, cnt_x_ff};
					`MRR_OFS_YCNT: wb_dat_o <= {24'h000000, cnt_y_ff};
					`MRR_OFS_SURFACE_QUALITY: wb_dat_o <= {24'h000000, surface_quality_ff};
					`MRR_OFS_PIXSUM: wb_dat_o <= {24'h000000, pix_hi_ff};
					`MRR_OFS_PEAK: wb_dat_o <= {26'h0000000, peak_ff};
					`MRR_OFS_SETUP: wb_dat_o <= {24'h000000, setup_ff};
					`MRR_OFS_IRQ_STAT: wb_dat_o <= {29'h00000000, irq_stat_ff};
					`MRR_OFS_IRQ_MASK: wb_dat_o <= {29'h00000000, irq_mask_ff};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
			if (wr && wb_adr_i == `MRR_OFS_SETUP)
				setup_ff <= (wb_dat_i[7:0] & `MRR_SETUP_WMASK) | `MRR_SETUP_FIXED;
			if (wr && wb_adr_i == `MRR_OFS_IRQ_MASK)
				irq_mask_ff <= wb_dat_i[2:0];
		end
	end

	// sticky events, write one to clear, set wins
	always @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_stat_ff <= 3'h0;
			irq_o <= 1'b0;
			res_sel_o <= 2'b00;
			laser_mode_o <= 1'b0;
			sys_test_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			irq_stat_ff <= (irq_stat_ff &
				~((wr && wb_adr_i == `MRR_OFS_IRQ_STAT) ? wb_dat_i[2:0] : 3'h0)) |
				{frame_end_i, ovf_evt, mot_valid_i &&
				(mot_dx_i != {DELTA_W{1'b0}} || mot_dy_i != {DELTA_W{1'b0}})};
			irq_o <= |(irq_stat_ff & irq_mask_ff);
			res_sel_o <= {setup_ff[`MRR_CFG_RESOLUTION_HIGH_BIT], setup_ff[`MRR_CFG_RESOLUTION_LOW_BIT]};
			laser_mode_o <= setup_ff[6];
			sys_test_o <= setup_ff[5];
		end
	end

endmodule // mrr_motion_regs

// >>> sim/mrr_motion_regs_asserts.sv
// port checker for the motion report register set
`timescale 1ns/1ps
module mrr_motion_regs_asserts (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	input wire clk_en_i,
	// wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// configuration and interrupt
	input wire [1:0] res_sel_o,
	input wire laser_mode_o,
	input wire sys_test_o,
	input wire irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	wire rd_ack = wb_ack_o && !wb_we_i;
	wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
	wire [3:0] set_v = {wb_dat_i[6], wb_dat_i[5], wb_dat_i[4], wb_dat_i[2]};
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i |=> wb_ack_o)
		else $error("no ack after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_peak_top: assert property (
		rd_ack && wb_adr_i == 8'h07 |-> wb_dat_o[7:6] == 2'h0) else $error("peak top bits set");
	chk_surface_quality_max: assert property (
		rd_ack && wb_adr_i == 8'h05 |-> wb_dat_o[7:0] <= 8'ha9) else $error("quality above max");
	chk_res_echo: assert property (
		rd_ack && wb_adr_i == 8'h02 |-> {wb_dat_o[2], wb_dat_o[0]} == res_sel_o)
		else $error("status resolution bits wrong");
	chk_setup_out: assert property (wr_ack && wb_adr_i == 8'h0a
		|=> {laser_mode_o, sys_test_o, res_sel_o} == $past(set_v)) else $error("setup outputs");
	chk_irq_masked: assert property (wr_ack && wb_adr_i == 8'h21 && wb_dat_i[2:0] == 3'h0
		|=> !irq_o) else $error("irq while masked");
	cover property (rd_ack && wb_adr_i == 8'h02 && wb_dat_o[4]);
	cover property (wr_ack && wb_adr_i == 8'h12);
	cover property (irq_o);
endmodule // mrr_motion_regs_asserts
bind mrr_motion_regs mrr_motion_regs_asserts u_chk (.*);

// >>> sim/mrr_nav_model.sv
// navigation engine model that streams one frame of pixels and features
`timescale 1ns/1ps
module mrr_nav_model (
	// control
	input wire ref_clk_i,
	input wire go_i,
	input wire [9:0] feat_n_i,
	// frame stream
	output logic pix_valid_o,
	output logic [5:0] pix_val_o,
	output logic frame_start_o,
	output logic frame_end_o,
	output logic feat_valid_o
);
	initial
	begin
		{pix_valid_o, pix_val_o, frame_start_o, frame_end_o, feat_valid_o} = 0;
		forever
		begin
			@(posedge ref_clk_i);
			if (go_i)
			begin
				frame_start_o <= 1;
				@(posedge ref_clk_i);
				frame_start_o <= 0;
				for (int i = 0; i < 900; i++)
				begin
					pix_valid_o <= 1;
					pix_val_o <= i[5:0];
					feat_valid_o <= (i < feat_n_i);
					@(posedge ref_clk_i);
				end
				pix_valid_o <= 0;
				pix_val_o <= 6'h2a;
				feat_valid_o <= 0;
				frame_end_o <= 1;
				@(posedge ref_clk_i);
				frame_end_o <= 0;
			end
		end
	end
endmodule // mrr_nav_model

// >>> sim/mrr_motion_regs_tb_top.sv
// self-checking bench for the motion report register set
`timescale 1ns/1ps
module mrr_motion_regs_tb_top;
	logic ref_clk_i = 0, resetn_i = 0, clk_en_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 0, mot_dx_i = 0, mot_dy_i = 0, rd_v;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 0;
	logic mot_valid_i = 0, go = 0, pix_valid_i, frame_start_i, frame_end_i, feat_valid_i;
	logic [5:0] pix_val_i;
	logic [9:0] feat_n = 10'd700;
	logic [7:0] rst_ad [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
	wire [31:0] wb_dat_o;
	wire wb_ack_o, laser_mode_o, sys_test_o, irq_o;
	wire [1:0] res_sel_o;
	int n_mismatch = 0, total_checks = 0, ticks = 0;
	mrr_motion_regs u_dut (.*);
	mrr_nav_model u_nav (.ref_clk_i(ref_clk_i), .go_i(go), .feat_n_i(feat_n),
		.pix_valid_o(pix_valid_i), .pix_val_o(pix_val_i), .frame_start_o(frame_start_i),
		.frame_end_o(frame_end_i), .feat_valid_o(feat_valid_i));
	initial
	begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk_i)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			n_mismatch++;
			end_sim;
		end
	end
	task chk8(input [7:0] g, input [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t byte %h exp %h", $time, g, e);
		end
	endtask
	task chk1(input g, input e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t flag %b exp %b", $time, g, e);
		end
	endtask
	// one classic cycle, held until ack
	task bus(input w, input [7:0] a, input [7:0] d);
		@(posedge ref_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, 1'b1, w, a, 24'h0, d};
		do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
		rd_v = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		bus(0, a, 8'h00);
		chk8(rd_v, e);
	endtask
	task mv(input [7:0] x, input [7:0] y, input int n);
		@(posedge ref_clk_i);
		{mot_valid_i, mot_dx_i, mot_dy_i} <= {1'b1, x, y};
		repeat (n) @(posedge ref_clk_i);
		{mot_valid_i, mot_dx_i, mot_dy_i} <= {1'b0, ~x, ~y};
	endtask
	task t_reset;
		rdc(8'h0a, 8'h49);
		foreach (rst_ad[i]) rdc(rst_ad[i], 8'h00);
		$display("test reset done");
	endtask
	task t_motion;
		mv(8'h05, 8'hfd, 1);
		rdc(8'h02, 8'h80);
		rdc(8'h03, 8'h05);
		rdc(8'h04, 8'hfd);
		rdc(8'h03, 8'h00);
		rdc(8'h02, 8'h00);
		mv(8'h03, 8'h00, 1);
		rdc(8'h02, 8'h80);
		mv(8'h04, 8'h00, 1);
		rdc(8'h02, 8'h80);
		rdc(8'h03, 8'h04);
		rdc(8'h04, 8'h00);
		$display("test motion done");
	endtask
	task t_ovf;
		mv(8'h7f, 8'h00, 20);
		rdc(8'h02, 8'h90);
		rdc(8'h03, 8'h7f);
		rdc(8'h04, 8'h00);
		rdc(8'h02, 8'h80);
		rdc(8'h03, 8'h7f);
		bus(1, 8'h12, 8'h00);
		rdc(8'h02, 8'h00);
		rdc(8'h03, 8'h00);
		$display("test overflow done");
	endtask
	// frozen clock enable must swallow motion
	task t_freeze;
		@(posedge ref_clk_i) clk_en_i <= 1'b0;
		mv(8'h01, 8'h01, 3);
		@(posedge ref_clk_i) clk_en_i <= 1'b1;
		rdc(8'h02, 8'h00);
		$display("test freeze done");
	endtask
	// host drains residue by repeated status, X, Y reads
	task t_drain;
		mv(8'h7f, 8'h00, 4);
		repeat (4)
		begin
			rdc(8'h02, 8'h80);
			rdc(8'h03, 8'h7f);
			rdc(8'h04, 8'h00);
		end
		rdc(8'h02, 8'h00);
		$display("test drain done");
	endtask
	task t_setup;
		bus(1, 8'h0a, 8'hff);
		rdc(8'h0a, 8'h7c);
		rdc(8'h02, 8'h05);
		bus(1, 8'h07, 8'h55);
		rdc(8'h07, 8'h00);
		$display("test setup done");
	endtask
	task t_frame;
		bus(1, 8'h20, 8'h07);
		bus(1, 8'h21, 8'h04);
		@(posedge ref_clk_i) go <= 1;
		@(posedge ref_clk_i) go <= 0;
		do @(posedge ref_clk_i); while (frame_end_i !== 1'b1);
		repeat (3) @(posedge ref_clk_i);
		chk1(irq_o, 1'b1);
		rdc(8'h05, 8'ha9);
		rdc(8'h06, 8'h6e);
		rdc(8'h07, 8'h3f);
		bus(1, 8'h20, 8'h04);
		@(posedge ref_clk_i);
		chk1(irq_o, 1'b0);
		bus(1, 8'h21, 8'h00);
		$display("test frame done");
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		resetn_i <= 1;
		t_reset;
		t_motion;
		t_ovf;
		t_freeze;
		t_drain;
		t_setup;
		t_frame;
		end_sim;
	end
endmodule // mrr_motion_regs_tb_top
